// >>> rtl/lsslc_top.v
// Digital control of a 16-channel sink driver: shift register, latch, blank, stagger
//
// Function
// - Each shift clock rising edge moves the 16-bit shift register toward MSB.
// - Serial input level is captured into the LSB at each shift rising edge.
// - Chain output shows the MSB and changes only at a shift rising edge.
// - While latch input is high the output latch follows the shift register.
// - Shifting while latch is high changes latch and outputs with every shift.
// - While latch input is low the output latch holds, whatever shifting occurs.
// - Blank high forces every sink output off regardless of latch contents.
// - Blank low: output on when its latch bit is 1, off when 0.
// - Shift register and latch have no defined power-up value.
// - Outputs switch in nine staggered groups: 0, 1/15 .. 7/9, then 8.
// - Stagger applies to on and off when blank changes either way.
// - Stagger applies when latch contents change; final state set by latch and blank.
`include "lsslc_defines.vh"
`default_nettype none

module lsslc_top #(
    parameter CHANNELS   = `LSSLC_CHANNELS,
    parameter FIFO_DEPTH = `LSSLC_FIFO_DEPTH,
    parameter STAGGER    = `LSSLC_STAGGER_CYC
) (
    // Clock and reset
    input  wire                I_CLK,
    input  wire                I_RESETN,
    // Serial link from the display controller
    input  wire                I_SHIFT_CLK,
    input  wire                I_SERIAL_IN,
    input  wire                I_LATCH_TRANSPARENT,
    input  wire                I_BLANK,
    // Serial chain to the next device
    output wire                O_SERIAL_CHAIN_OUT,
    // Sink outputs, high means on
    output wire [CHANNELS-1:0] O_SINK_OUTPUT_N,
    // Stagger status
    output wire                O_STAGGER_BUSY,
    output wire                O_PENDING_FULL
);
    // Pin positions inside the synchroniser vectors
    localparam PIN_BLANK = 0;
    localparam PIN_SCLK  = 1;
    localparam PIN_LAT   = 2;
    localparam PIN_SIN   = 3;
    localparam PINS      = 4;

    // Blank resets high in both stages; a low there would unblank for a cycle
    localparam [PINS-1:0] PIN_RESET = 4'h1;

    wire [PINS-1:0] pins_raw;
    wire [PINS-1:0] pins_s;
    reg             sclk_prev_q;

    assign pins_raw[PIN_BLANK] = I_BLANK;
    assign pins_raw[PIN_SCLK]  = I_SHIFT_CLK;
    assign pins_raw[PIN_LAT]   = I_LATCH_TRANSPARENT;
    assign pins_raw[PIN_SIN]   = I_SERIAL_IN;

    // Two flops per pin; only the second stage feeds any logic
    genvar p;
    generate
        for (p = 0; p < PINS; p = p + 1) begin : g_sync
            reg meta_q;
            reg sync_q;

            always @(posedge I_CLK or negedge I_RESETN) begin
                if (!I_RESETN) begin
                    meta_q <= PIN_RESET[p];
                    sync_q <= PIN_RESET[p];
                end else begin
                    meta_q <= pins_raw[p];
                    sync_q <= meta_q;
                end
            end

            assign pins_s[p] = sync_q;
        end
    endgenerate

    // Previous shift clock level, reset to the idle low of the pin
    always @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= pins_s[PIN_SCLK];
        end
    end

    wire blank_s = pins_s[PIN_BLANK];
    wire sclk_s  = pins_s[PIN_SCLK];
    wire lat_s   = pins_s[PIN_LAT];
    wire sin_s   = pins_s[PIN_SIN];
    // Only rising edges act; falling edges are ignored
    wire sclk_rise = sclk_s & ~sclk_prev_q;

    // Shift register and latch carry no reset: contents are arbitrary at power-up
    reg [CHANNELS-1:0] shift_q;
    reg [CHANNELS-1:0] latch_q;
    wire [CHANNELS-1:0] shift_d = {shift_q[CHANNELS-2:0], sin_s};

    always @(posedge I_CLK) begin
        if (sclk_rise) begin
            shift_q <= shift_d;
        end
    end

    // Transparent latch modelled as a follower; shadows new shift data same cycle
    always @(posedge I_CLK) begin
        if (lat_s) begin
            latch_q <= sclk_rise ? shift_d : shift_q;
        end
    end
    // Latch low: no assignment, value held

    // Chain output is the MSB and moves only with shifts
    assign O_SERIAL_CHAIN_OUT = shift_q[CHANNELS-1];

    // Target pattern from latch and blank; bit n drives output n
    wire [CHANNELS-1:0] target = blank_s ? {CHANNELS{1'b0}} : latch_q;

    // Group of a channel: 0, pairs n/16-n, then 8 last
    function [3:0] group_of;
        input integer ch;
        begin
            case (ch[3:0])
                4'h0:    group_of = 4'h0;
                4'h1:    group_of = 4'h1;
                4'h2:    group_of = 4'h2;
                4'h3:    group_of = 4'h3;
                4'h4:    group_of = 4'h4;
                4'h5:    group_of = 4'h5;
                4'h6:    group_of = 4'h6;
                4'h7:    group_of = 4'h7;
                4'h8:    group_of = `LSSLC_LAST_GROUP;
                4'h9:    group_of = 4'h7;
                4'hA:    group_of = 4'h6;
                4'hB:    group_of = 4'h5;
                4'hC:    group_of = 4'h4;
                4'hD:    group_of = 4'h3;
                4'hE:    group_of = 4'h2;
                4'hF:    group_of = 4'h1;
                default: group_of = 4'h0;
            endcase
        end
    endfunction

    // Pending targets queue up so up to FIFO_DEPTH rapid latch updates are each staggered in order
    wire                fifo_in_ready;
    wire                fifo_out_valid;
    wire [CHANNELS-1:0] fifo_out_data;
    reg                 fifo_pop;
    reg  [CHANNELS-1:0] last_target_q;
    wire                target_change = (target != last_target_q);
    wire                target_push   = target_change & fifo_in_ready;

    // While the queue is full the newest target waits, so bursts coalesce

    always @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            last_target_q <= {CHANNELS{1'b0}};
        end else if (target_push) begin
            last_target_q <= target;
        end
    end

    lsslc_fifo #(
        .WIDTH (CHANNELS),
        .DEPTH (FIFO_DEPTH),
        .AW    (4)
    ) u_pending (
        .i_clk       (I_CLK),
        .i_resetn    (I_RESETN),
        .i_in_valid  (target_change),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (target),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (fifo_pop),
        .o_out_data  (fifo_out_data)
    );

    // Stagger walker: applies one group per step
    // One clock per group at least: a few-ns step is below the clock's resolution,
    // so the stagger here is coarser than on a bare driver die
    localparam [7:0] STEP_LAST = STAGGER[7:0] - 8'h01;

    localparam ST_IDLE = 1'b0;
    localparam ST_WALK = 1'b1;

    reg                 state_q;
    reg                 state_d;
    reg  [3:0]          group_q;
    reg  [3:0]          group_d;
    reg  [7:0]          step_q;
    reg  [7:0]          step_d;
    reg  [CHANNELS-1:0] goal_q;
    reg  [CHANNELS-1:0] goal_d;
    reg  [CHANNELS-1:0] out_q;
    wire [CHANNELS-1:0] out_d;

    always @* begin
        state_d  = state_q;
        group_d  = group_q;
        step_d   = step_q;
        goal_d   = goal_q;
        fifo_pop = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (fifo_out_valid) begin
                    fifo_pop = 1'b1;
                    goal_d   = fifo_out_data;
                    group_d  = 4'h0;
                    step_d   = 8'h00;
                    state_d  = ST_WALK;
                end
            end
            ST_WALK: begin
                if (step_q == STEP_LAST) begin
                    step_d = 8'h00;
                    if (group_q == `LSSLC_LAST_GROUP) begin
                        state_d = ST_IDLE;
                    end else begin
                        group_d = group_q + 4'h1;
                    end
                end else begin
                    step_d = step_q + 8'h01;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // First cycle of a group step
    wire apply_step = (state_q == ST_WALK) && (step_q == 8'h00);

    // Channel n takes its goal only in its own group's step
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : g_chan
            wire [3:0] chan_group = group_of(g);
            wire       chan_hit   = apply_step && (group_q == chan_group);
            assign out_d[g] = chan_hit ? goal_q[g] : out_q[g];
        end
    endgenerate

    // Walker state
    always @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Group being applied
    always @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            group_q <= 4'h0;
        end else begin
            group_q <= group_d;
        end
    end

    // Cycles spent in the current group
    always @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            step_q <= 8'h00;
        end else begin
            step_q <= step_d;
        end
    end

    // Goal word of the walk in flight
    always @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            goal_q <= {CHANNELS{1'b0}};
        end else begin
            goal_q <= goal_d;
        end
    end

    // Applied sink pattern; all off until the first walk
    always @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            out_q <= {CHANNELS{1'b0}};
        end else begin
            out_q <= out_d;
        end
    end

    // Sinks come straight from flops so no decode glitch reaches the pins
    assign O_SINK_OUTPUT_N = out_q;

    // Busy covers queued patterns too, not only the walk in flight
    assign O_STAGGER_BUSY  = (state_q == ST_WALK) | fifo_out_valid;

    // Full means new changes are held back and will coalesce
    assign O_PENDING_FULL  = ~fifo_in_ready;
endmodule // lsslc_top

`default_nettype wire

// >>> rtl/lsslc_defines.vh
// Shared constants for the LED sink shift/latch control block
`ifndef LSSLC_DEFINES_VH
`define LSSLC_DEFINES_VH

`define LSSLC_CHANNELS      16
`define LSSLC_GROUPS        9
`define LSSLC_GROUP_BITS    4
`define LSSLC_FIFO_WIDTH    16
`define LSSLC_FIFO_DEPTH    16
`define LSSLC_CLK_MHZ       10
// Stagger step between groups, in ns, and in cycles (never below one)
`define LSSLC_STAGGER_NS    1
`define LSSLC_STAGGER_CYC   (((`LSSLC_STAGGER_NS * `LSSLC_CLK_MHZ) / 1000) < 1 ? 1 : \
                             ((`LSSLC_STAGGER_NS * `LSSLC_CLK_MHZ) / 1000))
`define LSSLC_LAST_GROUP    4'h8

`endif

// >>> rtl/lsslc_fifo.v
// Synchronous valid/ready FIFO for latched output words
`default_nettype none

module lsslc_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // Clock and reset
    input  wire             i_clk,
    input  wire             i_resetn,
    // Fill side
    input  wire             i_in_valid,
    output wire             o_in_ready,
    input  wire [WIDTH-1:0] i_in_data,
    // Drain side
    output wire             o_out_valid,
    input  wire             i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_q;
    reg [AW-1:0]    rd_ptr_q;
    reg [AW:0]      count_q;
    wire            push;
    wire            pop;

    assign o_in_ready  = (count_q != DEPTH[AW:0]);
    assign o_out_valid = (count_q != {(AW+1){1'b0}});
    assign o_out_data  = mem[rd_ptr_q];
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    always @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr_q] <= i_in_data;
        end
    end

    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule // lsslc_fifo

`default_nettype wire

// >>> bench/lsslc_top_props.sv
// Port-level concurrent checks for the sink driver control block
`default_nettype none
module lsslc_top_props #(
    parameter CHANNELS = 16
) (
    input wire logic                I_CLK,
    input wire logic                I_RESETN,
    input wire logic                I_SHIFT_CLK,
    input wire logic                I_SERIAL_IN,
    input wire logic                I_LATCH_TRANSPARENT,
    input wire logic                I_BLANK,
    input wire logic                O_SERIAL_CHAIN_OUT,
    input wire logic [CHANNELS-1:0] O_SINK_OUTPUT_N,
    input wire logic                O_STAGGER_BUSY,
    input wire logic                O_PENDING_FULL
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RESETN);
    logic [CHANNELS-1:0] prev_q;
    logic [8:0]          grp;
    logic [7:0]          quiet_q, blank_q;
    always @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            quiet_q <= 8'h00;
            blank_q <= 8'h00;
        end else begin
            quiet_q <= (I_LATCH_TRANSPARENT || I_BLANK) ? 8'h00 : quiet_q + {7'h00, quiet_q != 8'hFF};
            blank_q <= !I_BLANK ? 8'h00 : blank_q + {7'h00, blank_q != 8'hFF};
        end
    end
    always @(posedge I_CLK) prev_q <= O_SINK_OUTPUT_N;
    // Fold pair members together so a legal step flips one group only
    always @* begin
        grp[0] = O_SINK_OUTPUT_N[0] ^ prev_q[0];
        grp[8] = O_SINK_OUTPUT_N[8] ^ prev_q[8];
        for (int k = 1; k < 8; k++)
            grp[k] = (O_SINK_OUTPUT_N[k] ^ prev_q[k]) | (O_SINK_OUTPUT_N[16-k] ^ prev_q[16-k]);
    end
    sequence s_blank_up;
        $rose(I_BLANK) ##1 I_BLANK [*3];
    endsequence
    property p_blank_off;
        s_blank_up |-> ##[1:250] (O_SINK_OUTPUT_N == '0);
    endproperty
    property p_blank_held;
        blank_q > 8'hFA |-> O_SINK_OUTPUT_N == '0;
    endproperty
    property p_serial;
        $changed(O_SERIAL_CHAIN_OUT) |-> $past(I_SHIFT_CLK) && !$past(I_SHIFT_CLK, 6);
    endproperty
    property p_serial_idle;
        !I_SHIFT_CLK [*6] |-> $stable(O_SERIAL_CHAIN_OUT);
    endproperty
    property p_one_group;
        $onehot0(grp);
    endproperty
    property p_chg_busy;
        $changed(O_SINK_OUTPUT_N) |-> $past(O_STAGGER_BUSY);
    endproperty
    property p_hold;
        quiet_q > 8'h3C |-> $stable(O_SINK_OUTPUT_N);
    endproperty
    property p_full_busy;
        O_PENDING_FULL |-> O_STAGGER_BUSY;
    endproperty
    a_blank_off: assert property (p_blank_off) else $error("sinks on after blank");
    a_blank_held: assert property (p_blank_held) else $error("sink on while blanked");
    a_serial: assert property (p_serial) else $error("chain out moved off a rise");
    a_serial_idle: assert property (p_serial_idle) else $error("chain out moved idle");
    a_one_group: assert property (p_one_group) else $error("two groups in one step");
    a_chg_busy: assert property (p_chg_busy) else $error("sinks moved outside walk");
    a_hold: assert property (p_hold) else $error("sinks moved with latch low");
    a_full_busy: assert property (p_full_busy) else $error("full while idle");
endmodule // lsslc_top_props

bind lsslc_top lsslc_top_props #(.CHANNELS(CHANNELS)) u_props (
    .I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_SHIFT_CLK(I_SHIFT_CLK),
    .I_SERIAL_IN(I_SERIAL_IN), .I_LATCH_TRANSPARENT(I_LATCH_TRANSPARENT),
    .I_BLANK(I_BLANK), .O_SERIAL_CHAIN_OUT(O_SERIAL_CHAIN_OUT),
    .O_SINK_OUTPUT_N(O_SINK_OUTPUT_N), .O_STAGGER_BUSY(O_STAGGER_BUSY),
    .O_PENDING_FULL(O_PENDING_FULL));
`default_nettype wire

// >>> bench/lsslc_ctl_model.sv
// Display controller model driving the link, latch and blank lines
`default_nettype none
module lsslc_ctl_model (
    input  wire logic i_clk,
    output var  logic o_shift_clk,
    output var  logic o_serial_in,
    output var  logic o_latch,
    output var  logic o_blank
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_shift_clk = 1'b0;
        o_serial_in = 1'b0;
        o_latch     = 1'b0;
        o_blank     = 1'b1; // Dark until data is latched
    end
    // 800 ns per bit; data steady across the rise, inverted afterwards
    task automatic send_bit(input logic b);
        @(negedge i_clk) o_serial_in = b;
        repeat (2) @(negedge i_clk);
        o_shift_clk = 1'b1;
        repeat (4) @(negedge i_clk);
        o_shift_clk = 1'b0;
        @(negedge i_clk) o_serial_in = ~b;
    endtask
    task automatic drive(input logic lat, input logic blk);
        @(negedge i_clk) o_latch = lat;
        o_blank = blk;
    endtask
endmodule // lsslc_ctl_model
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench for the sink driver control block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        sclk, serial_in, lat, blk, serial_chain_out, busy, full, seen;
    logic [15:0] sinks, exp_sr;
    int          bad_count = 0;
    int          total_checks = 0;
    int          n_sh = 0;
    always #50 clk = ~clk;
    lsslc_ctl_model u_ctl (.i_clk(clk), .o_shift_clk(sclk), .o_serial_in(serial_in),
        .o_latch(lat), .o_blank(blk));
    lsslc_top #(.CHANNELS(16), .FIFO_DEPTH(16), .STAGGER(1)) u_dut (
        .I_CLK(clk), .I_RESETN(resetn), .I_SHIFT_CLK(sclk), .I_SERIAL_IN(serial_in),
        .I_LATCH_TRANSPARENT(lat), .I_BLANK(blk), .O_SERIAL_CHAIN_OUT(serial_chain_out),
        .O_SINK_OUTPUT_N(sinks), .O_STAGGER_BUSY(busy), .O_PENDING_FULL(full));
    task automatic check(input logic [15:0] got, input logic [15:0] want);
        total_checks++;
        if (got !== want) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, got, want);
        end
    endtask
    task automatic conclude;
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic settle;
        repeat (6) @(negedge clk);
        for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge clk);
    endtask
    task automatic frame(input logic [15:0] w, input logic live);
        for (int i = 15; i >= 0; i--) begin
            u_ctl.send_bit(w[i]);
            exp_sr = {exp_sr[14:0], w[i]};
            n_sh++;
            if (n_sh >= 16) check({15'h0, serial_chain_out}, {15'h0, exp_sr[15]});
            if (live) begin
                settle();
                check(sinks, exp_sr);
            end
        end
    endtask
    // Expect groups 0, 1/15 .. 7/9, 8, one step each
    task automatic walk(input logic on);
        logic [15:0] prev, m;
        int          k;
        k = 0;
        prev = sinks;
        for (int c = 0; c < 40; c++) begin
            @(negedge clk);
            if (sinks !== prev) begin
                m = 16'((17'h1 << (k + 1)) - 17'h1) | 16'(16'hFFFF << (16 - k));
                check(sinks, on ? m : ~m);
                k++;
                prev = sinks;
            end
        end
        check(16'(k), 16'h0009);
    endtask
    task automatic t_reset;
        repeat (2) @(negedge clk);
        check(sinks, 16'h0000);
        resetn = 1'b1;
        $display("test reset done");
    endtask
    task automatic t_load;
        frame(16'hA5C3, 1'b0);
        u_ctl.drive(1'b1, 1'b1);
        repeat (4) @(negedge clk);
        u_ctl.drive(1'b0, 1'b1);
        repeat (120) @(negedge clk);
        check(sinks, 16'h0000);
        u_ctl.drive(1'b0, 1'b0);
        settle();
        check(sinks, 16'hA5C3);
        $display("test load done");
    endtask
    task automatic t_latch;
        frame(16'h1234, 1'b0);
        check(sinks, 16'hA5C3);
        u_ctl.drive(1'b1, 1'b0);
        settle();
        check(sinks, 16'h1234);
        frame(16'hFFFF, 1'b1);
        u_ctl.drive(1'b0, 1'b0);
        $display("test latch done");
    endtask
    task automatic t_stagger;
        u_ctl.drive(1'b0, 1'b1);
        walk(1'b0);
        u_ctl.drive(1'b0, 1'b0);
        walk(1'b1);
        seen = 1'b0;
        // Blank toggles faster than a walk, so pending changes pile up
        for (int i = 0; i < 40; i++) begin
            u_ctl.drive(1'b0, i[0]);
            repeat (2) @(negedge clk);
            if (full === 1'b1) seen = 1'b1;
        end
        settle();
        check({15'h0, seen}, 16'h0001);
        check(sinks, 16'h0000);
        frame(16'h0000, 1'b0);
        u_ctl.drive(1'b0, 1'b0);
        settle();
        u_ctl.drive(1'b1, 1'b0);
        walk(1'b0);
        $display("test stagger done");
    endtask
    initial begin
        t_reset();
        t_load();
        t_latch();
        t_stagger();
        conclude();
    end
    initial begin
        #2000000;
        bad_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        conclude();
    end
endmodule // tb
`default_nettype wire
